// >>> src/spr_ctrl.sv
// controller end: servo-on sequencing, rate-limited step pulses, clear, index
`timescale 1ns/1ns
`default_nettype none
module spr_ctrl
  import spr_pkg::*;
#(
  parameter int WAIT_CYC = SON_SETTLE_CYC,
  parameter int WAIT_BRAKE_CYC = SON_BRAKE_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // pins towards the drive
  spr_if.host pins,
  // configuration
  input wire logic brake_fitted,
  input wire logic dual_mode,
  input wire logic open_collector,
  // commands
  input wire logic servo_cmd,
  input wire logic emergency_stop_signal,
  input wire logic clear_cmd,
  input wire logic step_req,
  input wire logic step_dir,
  // status
  output logic step_ready,
  output logic clear_busy,
  output logic index_seen,
  output logic fault_seen,
  output logic brake_released
);

  // all state of the controller end
  typedef struct packed {
    logic son;
    logic [CNT_W-1:0] wait_cnt; // settle wait after servo-on
    logic armed;
    logic clr;
    logic [CLR_W-1:0] clr_cnt;
    logic [GAP_W-1:0] gap; // cycles until the next step may start
    logic [GAP_W-1:0] high; // pulse high time left
    logic sign;
    logic pul; // pulse pin
    logic fpin;
    logic rpin;
    logic ready;
    logic idx_q;
    logic idx_seen;
    logic fault;
    logic brake;
  } spr_ctl_st_t;

  spr_ctl_st_t st_r; // registered state
  spr_ctl_st_t st_nxt; // next state

  logic [GAP_W-1:0] per; // step period for the signalling in use
  logic take; // step taken this cycle

  // next-state logic
  always_comb begin
    st_nxt = st_r;
    // open collector runs slower; conducting drives the pin high
    per = open_collector ? GAP_W'(PER_OC_CYC) : GAP_W'(PER_LD_CYC);
    // emergency stop drops servo-on at once
    st_nxt.son = servo_cmd & ~emergency_stop_signal;
    if (!st_r.son) begin
      st_nxt.wait_cnt = '0;
      st_nxt.armed = 1'b0;
    end else if (!st_r.armed) begin
      st_nxt.wait_cnt = st_r.wait_cnt + CNT_W'(1);
      // a braked motor needs the longer wait
      if (st_r.wait_cnt == (brake_fitted ? CNT_W'(WAIT_BRAKE_CYC - 1)
                                         : CNT_W'(WAIT_CYC - 1))) begin
        st_nxt.armed = 1'b1;
      end
    end

    // step pacing
    if (st_r.gap != '0) begin
      st_nxt.gap = st_r.gap - GAP_W'(1);
    end
    if (st_r.high != '0) begin
      st_nxt.high = st_r.high - GAP_W'(1);
    end else begin
      st_nxt.pul = 1'b0;
      st_nxt.fpin = 1'b0;
      st_nxt.rpin = 1'b0;
    end
    take = 1'b0;
    if (st_r.ready && step_req) begin
      if (!dual_mode && st_r.sign != step_dir) begin
        // sign moves first; the request waits out the setup time
        st_nxt.sign = step_dir;
        st_nxt.gap = GAP_W'(SIGN_SETUP_CYC);
      end else begin
        take = 1'b1;
        st_nxt.gap = per;
        st_nxt.high = per >> 1;
        st_nxt.pul = ~dual_mode;
        st_nxt.fpin = dual_mode & step_dir;
        st_nxt.rpin = dual_mode & ~step_dir;
      end
    end
    st_nxt.ready = st_nxt.armed && st_nxt.son && (st_nxt.gap == '0) && !take;

    // clear held for the least time, not retriggered while busy
    if (st_r.clr) begin
      if (st_r.clr_cnt == CLR_W'(CLR_MIN_CYC - 1)) begin
        st_nxt.clr = 1'b0;
        st_nxt.clr_cnt = '0;
      end else begin
        st_nxt.clr_cnt = st_r.clr_cnt + CLR_W'(1);
      end
    end else if (clear_cmd) begin
      st_nxt.clr = 1'b1;
    end

    // only the rising edge of the index output counts
    st_nxt.idx_q = pins.index_phase_output;
    st_nxt.idx_seen = pins.index_phase_output & ~st_r.idx_q;
    st_nxt.fault = pins.fault_output;
    st_nxt.brake = pins.brake_release_output;
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign pins.servo_on = st_r.son;
  assign pins.step_pulse_input = st_r.pul;
  assign pins.direction_sign = st_r.sign;
  assign pins.forward_step_input = st_r.fpin;
  assign pins.reverse_step_input = st_r.rpin;
  assign pins.deviation_clear_input = st_r.clr;
  assign step_ready = st_r.ready;
  assign clear_busy = st_r.clr;
  assign index_seen = st_r.idx_seen;
  assign fault_seen = st_r.fault;
  assign brake_released = st_r.brake;

endmodule : spr_ctrl
`default_nettype wire

// >>> src/spr_drive.sv
// drive end: reference pulse decoder, error counter, brake, alarm, indicators
`timescale 1ns/1ns
`default_nettype none
module spr_drive
  import spr_pkg::*;
#(
  parameter int SETTLE_CYC = SON_SETTLE_CYC,
  parameter int BRAKE_CYC = BRAKE_LAG_CYC,
  parameter int ACT_CYC = ACT_HOLD_CYC,
  parameter int BLINK_CYC = BLINK_HALF_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // pins towards the controller
  spr_if.dev pins,
  // drive internals
  input wire logic [SEL_W-1:0] pulse_select,
  input wire logic [2:0] fault_detect,
  input wire logic index_event,
  // error counter and step stream
  output logic signed [ERR_W-1:0] pos_error,
  output logic hold_position,
  output logic servo_ready,
  output logic ref_step,
  output logic ref_dir,
  // indicators
  output logic ref_led_orange,
  output logic ref_led_green,
  output logic alarm_led_one,
  output logic alarm_led_two,
  output logic alarm_led_three
);

  // all state of the drive end
  typedef struct packed {
    logic [2:0] pin_q; // last pulse, forward, reverse levels
    logic son; // registered servo-on
    logic [CNT_W-1:0] son_cnt; // settle timer
    logic armed; // steps accepted
    logic brake; // brake release level
    logic [CNT_W-1:0] brk_cnt; // brake lag timer
    logic [CLR_W-1:0] clr_cnt; // clear qualification timer
    logic hold; // clear in force
    logic signed [ERR_W-1:0] err; // position error
    logic [REV_W-1:0] rev_cnt; // steps since last index
    logic [2:0] alarm; // sticky alarm causes
    logic fault; // alarm pin
    logic [IDX_W-1:0] idx_cnt; // index delay and width
    logic index; // index pin
    logic [CNT_W-1:0] act_cnt; // pulse activity timer
    logic [CNT_W-1:0] blink_cnt; // blink half period
    logic blink; // blink phase
    logic led_orange;
    logic led_green;
    logic step;
    logic dir;
  } spr_drv_st_t;

  spr_drv_st_t st_r; // registered state
  spr_drv_st_t st_nxt; // next state

  // step weight from the resolution field
  function automatic logic [ERR_W-1:0] spr_weight(input logic [SEL_W-1:0] sel);
    logic [1:0] sh;
    sh = sel[SEL_RES_LSB +: 2];
    spr_weight = ERR_W'(1) << sh;
  endfunction : spr_weight

  // combinational decode feeding the next state
  logic rise_p; // pulse pin rising edge
  logic rise_f; // forward pin rising edge
  logic rise_r; // reverse pin rising edge
  logic fwd; // accepted forward step
  logic rev; // accepted reverse step
  logic accept; // steps allowed now
  logic speed_err; // too many steps per turn
  logic [ERR_W-1:0] w; // step weight

  // next-state logic
  always_comb begin
    st_nxt = st_r;
    w = spr_weight(pulse_select);
    // pin levels taken as given: a conducting source transistor is high
    rise_p = pins.step_pulse_input & ~st_r.pin_q[0];
    rise_f = pins.forward_step_input & ~st_r.pin_q[1];
    rise_r = pins.reverse_step_input & ~st_r.pin_q[2];
    st_nxt.pin_q = {pins.reverse_step_input, pins.forward_step_input, pins.step_pulse_input};
    // a fault, an open settle window or a clear in force discards steps
    accept = st_r.armed & ~st_r.fault & ~st_r.hold;
    // edge detect at 25 MHz covers 0.65 us widths, so full rate decodes
    if (pulse_select[SEL_FMT_BIT] == FMT_DUAL_PULSE) begin
      fwd = accept & rise_f & ~rise_r;
      rev = accept & rise_r & ~rise_f;
    end else begin
      fwd = accept & rise_p & pins.direction_sign;
      rev = accept & rise_p & ~pins.direction_sign;
    end
    st_nxt.step = fwd | rev;
    // direction shown for the step in the same cycle, else held
    if (fwd | rev) begin
      st_nxt.dir = fwd;
    end

    // servo-on and settle window before steps count
    st_nxt.son = pins.servo_on;
    if (!st_r.son) begin
      st_nxt.son_cnt = '0;
      st_nxt.armed = 1'b0;
    end else if (!st_r.armed) begin
      st_nxt.son_cnt = st_r.son_cnt + CNT_W'(1);
      if (st_r.son_cnt == CNT_W'(SETTLE_CYC - 1)) begin
        st_nxt.armed = 1'b1;
      end
    end

    // brake follows the servo state after a fixed lag, both ways
    if (st_r.brake != st_r.son) begin
      st_nxt.brk_cnt = st_r.brk_cnt + CNT_W'(1);
      if (st_r.brk_cnt == CNT_W'(BRAKE_CYC - 1)) begin
        st_nxt.brake = st_r.son;
        st_nxt.brk_cnt = '0;
      end
    end else begin
      // a servo change that reverts inside the lag cancels it
      st_nxt.brk_cnt = '0;
    end

    // clear acts once held long enough; short glitches do nothing
    if (pins.deviation_clear_input) begin
      if (st_r.clr_cnt != CLR_W'(CLR_MIN_CYC - 1)) begin
        st_nxt.clr_cnt = st_r.clr_cnt + CLR_W'(1);
      end else begin
        st_nxt.hold = 1'b1;
      end
    end else begin
      st_nxt.clr_cnt = '0;
      st_nxt.hold = 1'b0;
    end

    // signed error counter
    if (st_r.hold) begin
      st_nxt.err = '0;
    end else if (fwd) begin
      st_nxt.err = st_r.err + $signed(w);
    end else if (rev) begin
      st_nxt.err = st_r.err - $signed(w);
    end

    // steps per revolution, restarted by each encoder index
    speed_err = st_r.rev_cnt > REV_W'(REV_LIMIT);
    if (index_event) begin
      st_nxt.rev_cnt = '0;
    end else if ((fwd | rev) && !speed_err) begin
      st_nxt.rev_cnt = st_r.rev_cnt + w[REV_W-1:0];
    end

    // alarms stick until reset; nothing but sys_rst clears them
    st_nxt.alarm = st_r.alarm | {fault_detect[2:1], fault_detect[0] | speed_err};
    // one cycle from detection, far inside the 2 ms bound
    st_nxt.fault = |st_nxt.alarm;

    // index output rises a fixed lag after the encoder mark
    if (st_r.idx_cnt != '0) begin
      st_nxt.idx_cnt = st_r.idx_cnt - IDX_W'(1);
    end else if (index_event) begin
      st_nxt.idx_cnt = IDX_W'(IDX_LAG_CYC + IDX_WIDTH_CYC);
    end
    st_nxt.index = (st_nxt.idx_cnt != '0) && (st_nxt.idx_cnt <= IDX_W'(IDX_WIDTH_CYC));

    // activity timer refreshed by every accepted step
    if (fwd | rev) begin
      st_nxt.act_cnt = CNT_W'(ACT_CYC);
    end else if (st_r.act_cnt != '0) begin
      st_nxt.act_cnt = st_r.act_cnt - CNT_W'(1);
    end
    // free-running blink phase
    if (st_r.blink_cnt == CNT_W'(BLINK_CYC - 1)) begin
      st_nxt.blink_cnt = '0;
      st_nxt.blink = ~st_r.blink;
    end else begin
      st_nxt.blink_cnt = st_r.blink_cnt + CNT_W'(1);
    end
    // reference indicator colour
    st_nxt.led_orange = ~st_r.son;
    if (!st_r.son) begin
      st_nxt.led_green = 1'b0;
    end else if (st_r.act_cnt != '0) begin
      st_nxt.led_green = st_r.blink;
    end else begin
      st_nxt.led_green = 1'b1;
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign pins.fault_output = st_r.fault;
  assign pins.brake_release_output = st_r.brake;
  assign pins.index_phase_output = st_r.index;
  assign pos_error = st_r.err;
  assign hold_position = st_r.hold;
  assign servo_ready = st_r.armed;
  assign ref_step = st_r.step;
  assign ref_dir = st_r.dir;
  assign ref_led_orange = st_r.led_orange;
  assign ref_led_green = st_r.led_green;
  assign alarm_led_one = st_r.alarm[0];
  assign alarm_led_two = st_r.alarm[1];
  assign alarm_led_three = st_r.alarm[2];

endmodule : spr_drive
`default_nettype wire

// >>> src/spr_if.sv
// pin bundle between the controller and the drive's reference input
`timescale 1ns/1ns
`default_nettype none
interface spr_if;
  logic servo_on; // servo enable, high = on
  logic step_pulse_input; // pulse pin in sign mode
  logic direction_sign; // sign pin, high = forward
  logic forward_step_input; // forward pulse pin in dual mode
  logic reverse_step_input; // reverse pulse pin in dual mode
  logic deviation_clear_input; // error counter clear, high = clear
  logic fault_output; // alarm, high = fault
  logic brake_release_output; // high = brake released
  logic index_phase_output; // once-per-turn mark
  modport dev (
    input servo_on, step_pulse_input, direction_sign, forward_step_input,
    input reverse_step_input, deviation_clear_input,
    output fault_output, brake_release_output, index_phase_output
  );
  modport host (
    output servo_on, step_pulse_input, direction_sign, forward_step_input,
    output reverse_step_input, deviation_clear_input,
    input fault_output, brake_release_output, index_phase_output
  );
endinterface : spr_if
`default_nettype wire

// >>> src/spr_pkg.sv
// shared constants for the pulse reference input, drive end and controller end
package spr_pkg;
  // core clock
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  // servo-on settle before the first step, plain and with a holding brake
  localparam int SON_SETTLE_MS = 40;
  localparam int SON_BRAKE_MS = 100;
  localparam int SON_SETTLE_CYC = SON_SETTLE_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int SON_BRAKE_CYC = SON_BRAKE_MS * 1_000_000 / CLK_PERIOD_NS;
  // brake output lag after a servo state change
  localparam int BRAKE_LAG_MS = 100;
  localparam int BRAKE_LAG_CYC = BRAKE_LAG_MS * 1_000_000 / CLK_PERIOD_NS;
  // deviation clear least hold time, rounded up
  localparam int CLR_MIN_NS = 20_000;
  localparam int CLR_MIN_CYC = (CLR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest alarm latency allowed after a detected fault
  localparam int FAULT_MAX_MS = 2;
  localparam int FAULT_MAX_CYC = FAULT_MAX_MS * 1_000_000 / CLK_PERIOD_NS;
  // highest reference rates, line driver and open collector
  localparam int RATE_LD_HZ = 750_000;
  localparam int RATE_OC_HZ = 187_500;
  localparam int PER_LD_CYC = (CLK_HZ + RATE_LD_HZ - 1) / RATE_LD_HZ;
  localparam int PER_OC_CYC = (CLK_HZ + RATE_OC_HZ - 1) / RATE_OC_HZ;
  // sign setup before a pulse edge, strictly more than 3 us
  localparam int SIGN_SETUP_NS = 3_000;
  localparam int SIGN_SETUP_CYC = SIGN_SETUP_NS / CLK_PERIOD_NS + 1;
  // reference steps allowed per motor revolution
  localparam int REV_LIMIT = 10_000;
  // index output: fixed rise lag and width
  localparam int IDX_LAG_CYC = 4;
  localparam int IDX_WIDTH_CYC = 25;
  // indicator timing
  localparam int ACT_HOLD_MS = 50;
  localparam int ACT_HOLD_CYC = ACT_HOLD_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int BLINK_HALF_MS = 50;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1_000_000 / CLK_PERIOD_NS;
  // widths
  localparam int CNT_W = 23;
  localparam int ERR_W = 24;
  localparam int REV_W = 16;
  localparam int IDX_W = 6;
  localparam int GAP_W = 8;
  localparam int CLR_W = 10;
  // rotary selector fields: bit 0 format, bits 2:1 resolution shift
  localparam int SEL_W = 3;
  localparam int SEL_FMT_BIT = 0;
  localparam int SEL_RES_LSB = 1;
  localparam logic FMT_SIGN_PULSE = 1'b0;
  localparam logic FMT_DUAL_PULSE = 1'b1;
endpackage : spr_pkg

// >>> testbench/spr_pins_asserts.sv
// checker on the pin bundle between controller end and drive end
`timescale 1ns/1ns
`default_nettype none
module spr_pins_chk
  import spr_pkg::*;
#(
  parameter int BRAKE_CYC = BRAKE_LAG_CYC,
  parameter int WAIT_CYC = SON_SETTLE_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // controller driven pins
  input wire logic servo_on,
  input wire logic step_pulse_input,
  input wire logic direction_sign,
  input wire logic forward_step_input,
  input wire logic reverse_step_input,
  input wire logic deviation_clear_input,
  // drive driven pins
  input wire logic fault_output,
  input wire logic brake_release_output,
  input wire logic index_phase_output
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // any of the three pulse pins
  wire logic pulse_any = step_pulse_input | forward_step_input | reverse_step_input;
  logic [31:0] lag_r; // edges of servo and brake disagreeing
  logic [31:0] son_r; // edges with servo on
  logic [31:0] clr_r; // edges with clear high
  logic [31:0] idx_r; // edges with index high
  logic [7:0] gap_r; // edges since last pulse rise, saturating
  logic [7:0] sign_r; // edges since sign change, saturating
  // helper counters; gap and sign start saturated so the first step is not flagged
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lag_r <= 32'h0;
      son_r <= 32'h0;
      clr_r <= 32'h0;
      idx_r <= 32'h0;
      gap_r <= 8'hFF;
      sign_r <= 8'hFF;
    end else begin
      lag_r <= (servo_on == brake_release_output) ? 32'h0 : lag_r + 32'h1;
      son_r <= servo_on ? son_r + 32'h1 : 32'h0;
      clr_r <= deviation_clear_input ? clr_r + 32'h1 : 32'h0;
      idx_r <= index_phase_output ? idx_r + 32'h1 : 32'h0;
      gap_r <= $rose(pulse_any) ? 8'h0 : (gap_r == 8'hFF ? gap_r : gap_r + 8'h1);
      sign_r <= $changed(direction_sign) ? 8'h0 : (sign_r == 8'hFF ? sign_r : sign_r + 8'h1);
    end
  end
  brake_lag_a: assert property ($changed(brake_release_output) |->
    lag_r + 2 >= BRAKE_CYC && lag_r <= BRAKE_CYC + 3) else $error("brake moved off its lag");
  brake_bound_a: assert property (lag_r <= BRAKE_CYC + 4)
    else $error("brake never followed servo");
  fault_sticky_a: assert property (!$fell(fault_output))
    else $error("alarm dropped without reset");
  index_width_a: assert property ($fell(index_phase_output) |-> idx_r == IDX_WIDTH_CYC)
    else $error("index width wrong");
  index_bound_a: assert property (idx_r <= IDX_WIDTH_CYC)
    else $error("index too long");
  servo_wait_a: assert property ($rose(pulse_any) |-> servo_on && son_r + 1 >= WAIT_CYC)
    else $error("step too soon after servo on");
  clear_hold_a: assert property ($fell(deviation_clear_input) |-> clr_r >= CLR_MIN_CYC)
    else $error("clear too short");
  step_rate_a: assert property ($rose(pulse_any) |-> gap_r + 1 >= PER_LD_CYC)
    else $error("step rate too high");
  pulse_width_a: assert property ($rose(pulse_any) |-> pulse_any [*8])
    else $error("step pulse too narrow");
  sign_setup_a: assert property ($rose(step_pulse_input) |-> sign_r + 1 >= SIGN_SETUP_CYC)
    else $error("sign setup too short");
  // main scenarios
  cover property ($rose(brake_release_output));
  cover property ($fell(deviation_clear_input));
  cover property ($rose(index_phase_output));
  cover property ($rose(forward_step_input));
endmodule : spr_pins_chk
`default_nettype wire

// >>> testbench/test_servo_pulse_reference_input.sv
// bench: controller end drives drive end through the pin bundle
`timescale 1ns/1ns
`default_nettype none
module test_servo_pulse_reference_input
  import spr_pkg::*;
;
  localparam int B_CYC = 60; // shortened brake lag
  localparam int W_CYC = 50; // shortened controller wait, no brake
  localparam int WB_CYC = 70; // shortened controller wait with a brake
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [SEL_W-1:0] pulse_select = 3'h0;
  logic [2:0] fault_detect = 3'h0;
  logic index_event = 1'b0, brake_fitted = 1'b0, dual_mode = 1'b0, open_collector = 1'b0;
  logic servo_cmd = 1'b0, emergency_stop_signal = 1'b0, clear_cmd = 1'b0;
  logic step_req = 1'b0, step_dir = 1'b0;
  logic signed [ERR_W-1:0] pos_error, exp_err = 24'h0;
  logic hold_position, servo_ready, ref_step, ref_dir, ref_led_orange, ref_led_green;
  logic alarm_led_one, alarm_led_two, alarm_led_three;
  logic step_ready, clear_busy, index_seen, fault_seen, brake_released;
  logic hold_seen = 1'b0; // clear reached the drive
  int bad_count = 0, n_tests = 0, cyc = 0, gl = 0, n;
  int n_clr = 0, n_idx = 0, n_ref = 0, n_req = 0; // index and step pulse counts, clear width in cycles, requested steps
  spr_if i_spr_if ();
  spr_drive #(.SETTLE_CYC(40), .BRAKE_CYC(B_CYC), .ACT_CYC(50), .BLINK_CYC(20)) i_spr_drive (
    .core_clk(core_clk), .sys_rst(sys_rst), .pins(i_spr_if), .pulse_select(pulse_select),
    .fault_detect(fault_detect), .index_event(index_event), .pos_error(pos_error),
    .hold_position(hold_position), .servo_ready(servo_ready), .ref_step(ref_step),
    .ref_dir(ref_dir), .ref_led_orange(ref_led_orange), .ref_led_green(ref_led_green),
    .alarm_led_one(alarm_led_one), .alarm_led_two(alarm_led_two),
    .alarm_led_three(alarm_led_three));
  spr_ctrl #(.WAIT_CYC(W_CYC), .WAIT_BRAKE_CYC(WB_CYC)) i_spr_ctrl (
    .core_clk(core_clk), .sys_rst(sys_rst), .pins(i_spr_if), .brake_fitted(brake_fitted),
    .dual_mode(dual_mode), .open_collector(open_collector), .servo_cmd(servo_cmd),
    .emergency_stop_signal(emergency_stop_signal), .clear_cmd(clear_cmd),
    .step_req(step_req), .step_dir(step_dir), .step_ready(step_ready),
    .clear_busy(clear_busy), .index_seen(index_seen), .fault_seen(fault_seen),
    .brake_released(brake_released));
  spr_pins_chk #(.BRAKE_CYC(B_CYC), .WAIT_CYC(W_CYC)) i_spr_pins_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .servo_on(i_spr_if.servo_on),
    .step_pulse_input(i_spr_if.step_pulse_input), .direction_sign(i_spr_if.direction_sign),
    .forward_step_input(i_spr_if.forward_step_input),
    .reverse_step_input(i_spr_if.reverse_step_input),
    .deviation_clear_input(i_spr_if.deviation_clear_input),
    .fault_output(i_spr_if.fault_output),
    .brake_release_output(i_spr_if.brake_release_output),
    .index_phase_output(i_spr_if.index_phase_output));
  // 25 MHz clock
  always #20 core_clk = ~core_clk;
  // hang guard, well above the roughly 50k cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      $display("mismatch at %0t: timeout", $time);
      report_and_stop();
    end
  end
  // hold stands one cycle at the end of the 500-cycle clear, so latch it when seen
  always @(posedge core_clk) if (hold_position === 1'b1) hold_seen <= 1'b1;
  // count one-cycle pulses and the clear width; a pulse is seen once per edge
  always @(posedge core_clk) begin
    if (clear_busy === 1'b1) n_clr <= n_clr + 1;
    if (index_seen === 1'b1) n_idx <= n_idx + 1;
    if (ref_step === 1'b1) n_ref <= n_ref + 1;
  end
  task report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task chk_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s is %b", $time, what, got);
    end
  endtask : chk_bit
  task chk_err(input logic signed [ERR_W-1:0] exp);
    n_tests++;
    if (pos_error !== exp) begin
      bad_count++;
      $display("mismatch at %0t: error count %0d not %0d", $time, pos_error, exp);
    end
  endtask : chk_err
  task tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask : tick
  // one step; reads here see values from before this edge's updates
  task do_step(input logic d, input logic signed [ERR_W-1:0] w);
    step_req <= 1'b1;
    step_dir <= d;
    for (int i = 0; i < 400; i++) begin
      @(posedge core_clk);
      if (step_ready === 1'b1 && (dual_mode || i_spr_if.direction_sign === d)) break;
    end
    step_req <= 1'b0;
    exp_err = d ? exp_err + w : exp_err - w;
    n_req++;
    if (ref_led_green === 1'b0) gl++;
    @(posedge core_clk);
  endtask : do_step
  initial begin
    tick(3);
    sys_rst <= 1'b0;
    tick(3);
    chk_bit(ref_led_orange, 1'b1, "orange after reset");
    chk_bit(ref_led_green, 1'b0, "green after reset");
    $display("test reset done");
    servo_cmd <= 1'b1;
    brake_fitted <= 1'b1;
    tick(B_CYC - 5);
    chk_bit(i_spr_if.brake_release_output, 1'b0, "brake early");
    tick(12);
    chk_bit(i_spr_if.brake_release_output, 1'b1, "brake late");
    chk_bit(brake_released, 1'b1, "brake seen");
    chk_bit(step_ready, 1'b0, "brake wait");
    chk_bit(ref_led_green, 1'b1, "green on");
    chk_bit(ref_led_orange, 1'b0, "orange on");
    chk_bit(servo_ready, 1'b1, "settle");
    $display("test servo on done");
    repeat (3) do_step(1'b1, 24'h1);
    repeat (2) do_step(1'b0, 24'h1);
    tick(3);
    chk_err(exp_err);
    chk_bit(ref_dir, 1'b0, "reverse dir");
    pulse_select <= 3'h2;
    repeat (2) do_step(1'b1, 24'h2);
    tick(3);
    chk_err(exp_err);
    $display("test sign steps done");
    dual_mode <= 1'b1;
    open_collector <= 1'b1;
    pulse_select <= 3'h5;
    repeat (2) do_step(1'b1, 24'h4);
    do_step(1'b0, 24'h4);
    tick(3);
    chk_err(exp_err);
    chk_bit(ref_dir, 1'b0, "dual reverse");
    open_collector <= 1'b0;
    $display("test dual steps done");
    clear_cmd <= 1'b1;
    tick(1);
    clear_cmd <= 1'b0;
    tick(520);
    exp_err = 24'h0;
    chk_bit(hold_seen, 1'b1, "hold");
    chk_err(exp_err);
    chk_bit(hold_position, 1'b0, "hold release");
    chk_bit(n_clr == CLR_MIN_CYC, 1'b1, "clear width");
    $display("test clear done");
    index_event <= 1'b1;
    tick(1);
    index_event <= 1'b0;
    n = 0;
    while (n < 20 && i_spr_if.index_phase_output !== 1'b1) begin
      @(posedge core_clk);
      n++;
    end
    chk_bit(n == 1 + IDX_LAG_CYC, 1'b1, "index lag");
    tick(40);
    chk_bit(n_idx == 1, 1'b1, "index seen once");
    $display("test index done");
    pulse_select <= 3'h7;
    repeat (REV_LIMIT / 8) do_step(1'b1, 24'h8);
    tick(4);
    chk_bit(alarm_led_one, 1'b0, "speed at limit");
    do_step(1'b1, 24'h8);
    tick(4);
    chk_bit(alarm_led_one, 1'b1, "speed over");
    chk_bit(i_spr_if.fault_output, 1'b1, "alarm pin");
    chk_bit(fault_seen, 1'b1, "fault seen");
    chk_bit(n_ref == n_req, 1'b1, "step count");
    chk_bit(gl > 0, 1'b1, "blink");
    chk_err(exp_err);
    $display("test speed error done");
    fault_detect <= 3'h4;
    tick(1);
    fault_detect <= 3'h0;
    tick(1);
    chk_bit(alarm_led_three, 1'b1, "alarm three");
    chk_bit(alarm_led_two, 1'b0, "alarm two");
    $display("test fault done");
    emergency_stop_signal <= 1'b1;
    tick(2);
    chk_bit(i_spr_if.servo_on, 1'b0, "stop drops servo");
    tick(B_CYC - 5);
    chk_bit(i_spr_if.brake_release_output, 1'b1, "brake hold lag");
    tick(12);
    chk_bit(i_spr_if.brake_release_output, 1'b0, "brake applied");
    chk_bit(brake_released, 1'b0, "brake seen applied");
    chk_bit(ref_led_orange, 1'b1, "orange off");
    $display("test emergency stop done");
    // servo back on without a brake: the shorter wait applies
    brake_fitted <= 1'b0;
    emergency_stop_signal <= 1'b0;
    tick(W_CYC - 1);
    chk_bit(step_ready, 1'b0, "plain wait early");
    tick(4);
    chk_bit(step_ready, 1'b1, "plain wait");
    $display("test plain servo on done");
    report_and_stop();
  end
endmodule : test_servo_pulse_reference_input
`default_nettype wire
